// ---- hw/slf_regs.svh ----
// Offsets, field positions, reset values and command codes of the limit, interrupt and FIFO block
//
// Contract
// - Low limits reset to 0000h, high limits to FFFFh until the host writes them.
// - Limits compare with the upper 16 bits of the filtered conversion result.
// - Compare only at conversion end; a later limit write never re-compares.
// - In automatic mode with ratio above one, compare once per measurement.
// - Out-of-limit result sets its flag; pin driven only when masked in.
// - High flag when result above high limit; low flag when below low limit.
// - Mask bit zero hides a flag from the pin; the flag still sets.
// - All interrupt mask bits reset to zero.
// - Writing one clears a flag; zero bits leave flags unchanged.
// - Flag bit 7 reports the register CRC check: 1 means failed.
// - Temperature flags and done flag assert after the temperature step.
// - After first done, read returns new temperature with previous pressure.
// - FIFO holds 32 pairs in order; full mode drops results when full.
// - Update mode overwrites the oldest entry once 31 entries are held, cycling forever.
// - Read pointer advances at start of a FIFO read; aborted reads lose entry.
// - Update mode keeps at most 31 retrievable entries.
// - FIFO-full flag sets when 32 unread pairs are held.
// - Threshold flag sets when n unread pairs are held, n from 1 to 31.
// - FIFO flags update only at conversion end; storage continues past threshold.
// - FIFO mode off empties the FIFO and resets both pointers.
// - Configuration access is refused while automatic measurement runs.
// - Each stored pair reuses the latest temperature result.
// - Timer events with no scheduled conversion store nothing.
// - FIFO mode 0 off, 1 stop-when-full, 2 or 3 overwrite.
// - Threshold is a five-bit field; zero disables the threshold flag.
`ifndef SLF_REGS_SVH
`define SLF_REGS_SVH

`define SLF_LIMIT_LOW_RST 16'h0000
`define SLF_LIMIT_HIGH_RST 16'hFFFF
`define SLF_MASK_RST 8'h00
`define SLF_FLAGS_RST 8'h00

`define SLF_BIT_CRC 7
`define SLF_BIT_PHIGH 6
`define SLF_BIT_PLOW 5
`define SLF_BIT_THIGH 4
`define SLF_BIT_TLOW 3
`define SLF_BIT_FULL 2
`define SLF_BIT_THR 1
`define SLF_BIT_DONE 0

`define SLF_OP_THR_MSB 12
`define SLF_OP_THR_LSB 8
`define SLF_OP_MODE_MSB 7
`define SLF_OP_MODE_LSB 6

`define SLF_CMD_LIMIT_HI 4'h3
`define SLF_CMD_INT_HI 4'h1
`define SLF_LIM_P_LOW 2'h0
`define SLF_LIM_P_HIGH 2'h1
`define SLF_LIM_T_LOW 2'h2
`define SLF_LIM_T_HIGH 2'h3

`endif

// ---- hw/slf_pkg.sv ----
// Types shared by the limit, interrupt and FIFO block
package slf_pkg;
    typedef enum logic [1:0] {
        FIFO_OFF,
        FIFO_FULL_MODE,
        FIFO_UPDATE_MODE
    } slf_fifo_mode_e;

    // One conversion finishing, as seen by the result logic
    typedef struct packed {
        logic valid;
        logic isTemp;
        logic store;
        logic compare;
        logic [23:0] result;
    } slf_conv_s;

    // One host command byte with its data word
    typedef struct packed {
        logic valid;
        logic [7:0] cmd;
        logic [15:0] data;
    } slf_cmd_s;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } slf_rsp_s;

    typedef struct packed {
        logic valid;
        logic [23:0] temp;
        logic [23:0] press;
    } slf_pair_s;
endpackage : slf_pkg

// ---- hw/slf_result_unit.sv ----
// Limit comparison, interrupt flags and mask, result FIFO
`timescale 1ns/1ps
`include "slf_regs.svh"

module slf_result_unit #(
    parameter int DEPTH = 32,
    parameter int PTR_W = 5
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Conversion results from the converter and filter
    input wire slf_pkg::slf_conv_s conv,
    // Operating register fields and status
    input wire logic [15:0] opReg,
    input wire logic autoRun,
    input wire logic crcFail,
    // Decoded host commands
    input wire slf_pkg::slf_cmd_s cmd,
    input wire logic fifoRead,
    // Answers to the host
    output slf_pkg::slf_rsp_s rsp,
    output slf_pkg::slf_pair_s fifoData,
    output logic [23:0] lastTemp,
    output logic [23:0] lastPress,
    output logic cfgRefused,
    output logic intOut
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [3:0][15:0] limits;
        logic [7:0] flags;
        logic [7:0] mask;
        logic [23:0] temp;
        logic [23:0] press;
        logic [PTR_W-1:0] wrPtr;
        logic [PTR_W-1:0] rdPtr;
        logic [PTR_W:0] count;
        slf_pkg::slf_rsp_s rsp;
        slf_pkg::slf_pair_s fifoData;
        logic cfgRefused;
        logic intOut;
    } slf_state_s;

    slf_state_s state_q;
    slf_state_s state_d;
    logic [47:0] mem_q [DEPTH];

    localparam logic [PTR_W:0] DEPTH_C = (PTR_W+1)'(DEPTH);
    localparam logic [PTR_W:0] DEPTH_M1 = (PTR_W+1)'(DEPTH - 1);

    slf_pkg::slf_fifo_mode_e fifoMode;
    logic [4:0] thr;
    logic [15:0] msb16;
    logic doStore;
    logic doPush;
    logic [PTR_W:0] storeLim;
    logic doRead;
    logic isLimCmd;
    logic isIntCmd;
    logic [7:0] setMask;
    logic [7:0] clrMask;
    logic [23:0] pairT;
    logic [23:0] pairP;
    logic [PTR_W:0] cntNext;

    // ==========================================================
    // Decode
    always_comb begin
        unique case (opReg[`SLF_OP_MODE_MSB:`SLF_OP_MODE_LSB])
            2'h0: fifoMode = slf_pkg::FIFO_OFF;
            2'h1: fifoMode = slf_pkg::FIFO_FULL_MODE;
            default: fifoMode = slf_pkg::FIFO_UPDATE_MODE;
        endcase
        thr = opReg[`SLF_OP_THR_MSB:`SLF_OP_THR_LSB];
        msb16 = conv.result[23:8];
        isLimCmd = cmd.valid && cmd.cmd[7:4] == `SLF_CMD_LIMIT_HI;
        isIntCmd = cmd.valid && cmd.cmd[7:4] == `SLF_CMD_INT_HI && cmd.cmd[3];
    end

    // ==========================================================
    // Next state
    always_comb begin
        state_d = state_q;
        state_d.rsp.valid = 1'b0;
        state_d.fifoData.valid = 1'b0;
        setMask = 8'h00;
        clrMask = 8'h00;
        doStore = 1'b0;
        doPush = 1'b0;
        doRead = 1'b0;
        // Update mode stops one short of full so the cursors never meet
        storeLim = (fifoMode == slf_pkg::FIFO_UPDATE_MODE) ? DEPTH_M1 : DEPTH_C;
        pairT = state_q.temp;
        pairP = state_q.press;
        cntNext = state_q.count;

        // Host command handling
        if (isLimCmd) begin
            if (cmd.cmd[3]) begin
                state_d.rsp.valid = 1'b1;
                state_d.rsp.data = state_q.limits[cmd.cmd[2:1]];
            end else begin
                // Only future conversions see the new value; no re-compare
                state_d.limits[cmd.cmd[2:1]] = cmd.data;
            end
        end
        if (isIntCmd) begin
            if (cmd.cmd[1]) begin
                state_d.rsp.valid = 1'b1;
                state_d.rsp.data = {8'h00, cmd.cmd[2] ? state_q.flags : state_q.mask};
            end else if (cmd.cmd[2]) begin
                clrMask = cmd.data[7:0];
            end else begin
                state_d.mask = cmd.data[7:0];
            end
        end
        state_d.cfgRefused = cmd.valid && cmd.cmd[7:3] == 5'b00100 && autoRun;

        // Conversion end: flags raised at once per step
        if (conv.valid) begin
            setMask[`SLF_BIT_DONE] = 1'b1;
            if (conv.compare) begin
                if (conv.isTemp) begin
                    setMask[`SLF_BIT_THIGH] = msb16 > state_q.limits[`SLF_LIM_T_HIGH];
                    setMask[`SLF_BIT_TLOW] = msb16 < state_q.limits[`SLF_LIM_T_LOW];
                end else begin
                    setMask[`SLF_BIT_PHIGH] = msb16 > state_q.limits[`SLF_LIM_P_HIGH];
                    setMask[`SLF_BIT_PLOW] = msb16 < state_q.limits[`SLF_LIM_P_LOW];
                end
            end
            // Pressure stays old until its own step finishes
            if (conv.isTemp) begin
                state_d.temp = conv.result;
                pairT = conv.result;
            end else begin
                state_d.press = conv.result;
                pairP = conv.result;
            end
            // Skipped timer events never assert valid, so nothing is stored
            doStore = conv.store && fifoMode != slf_pkg::FIFO_OFF;
        end

        // FIFO
        doRead = fifoRead && state_q.count != '0 && fifoMode != slf_pkg::FIFO_OFF;
        if (doRead) begin
            state_d.fifoData.valid = 1'b1;
            state_d.fifoData.temp = mem_q[state_q.rdPtr][47:24];
            state_d.fifoData.press = mem_q[state_q.rdPtr][23:0];
            state_d.rdPtr = state_q.rdPtr + 1'b1;
            cntNext = cntNext - 1'b1;
        end
        if (doStore) begin
            if (cntNext < storeLim) begin
                doPush = 1'b1;
                state_d.wrPtr = state_q.wrPtr + 1'b1;
                cntNext = cntNext + 1'b1;
            end else if (fifoMode == slf_pkg::FIFO_UPDATE_MODE) begin
                // Oldest dropped so the reader never meets the writer
                doPush = 1'b1;
                state_d.wrPtr = state_q.wrPtr + 1'b1;
                state_d.rdPtr = state_d.rdPtr + 1'b1;
            end
            if (cntNext == DEPTH_C) begin
                setMask[`SLF_BIT_FULL] = 1'b1;
            end
            if (thr != 5'h00 && cntNext >= {1'b0, thr}) begin
                setMask[`SLF_BIT_THR] = 1'b1;
            end
        end
        state_d.count = cntNext;
        if (fifoMode == slf_pkg::FIFO_OFF) begin
            state_d.wrPtr = '0;
            state_d.rdPtr = '0;
            state_d.count = '0;
        end

        // Set wins over a simultaneous clear
        state_d.flags = (state_q.flags & ~clrMask) | setMask;
        state_d.flags[`SLF_BIT_CRC] = crcFail;
        state_d.intOut = |(state_d.flags & state_d.mask);
    end

    // ==========================================================
    // Registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= '0;
            state_q.limits[`SLF_LIM_P_LOW] <= `SLF_LIMIT_LOW_RST;
            state_q.limits[`SLF_LIM_T_LOW] <= `SLF_LIMIT_LOW_RST;
            state_q.limits[`SLF_LIM_P_HIGH] <= `SLF_LIMIT_HIGH_RST;
            state_q.limits[`SLF_LIM_T_HIGH] <= `SLF_LIMIT_HIGH_RST;
            state_q.mask <= `SLF_MASK_RST;
            state_q.flags <= `SLF_FLAGS_RST;
        end else begin
            state_q <= state_d;
        end
    end

    // Pair uses latest temperature when no new one arrived
    always_ff @(posedge core_clk) begin
        // A dropped full-mode store must not touch the oldest unread entry
        if (doPush) begin
            mem_q[state_q.wrPtr] <= {pairT, pairP};
        end
    end

    // ==========================================================
    // Outputs
    always_comb begin
        rsp = state_q.rsp;
        fifoData = state_q.fifoData;
        lastTemp = state_q.temp;
        lastPress = state_q.press;
        cfgRefused = state_q.cfgRefused;
        intOut = state_q.intOut;
    end
endmodule : slf_result_unit

// ---- dv/slf_result_unit_sva.sv ----
// Port assertions for the limit, interrupt and FIFO result unit
`timescale 1ns/1ps
module slf_result_unit_sva #(
    parameter int DEPTH = 32,
    parameter int PTR_W = 5
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Inputs watched
    input wire slf_pkg::slf_conv_s conv,
    input wire logic [15:0] opReg,
    input wire logic autoRun,
    input wire slf_pkg::slf_cmd_s cmd,
    input wire logic fifoRead,
    // Outputs watched
    input wire slf_pkg::slf_rsp_s rsp,
    input wire slf_pkg::slf_pair_s fifoData,
    input wire logic [23:0] lastTemp,
    input wire logic [23:0] lastPress,
    input wire logic cfgRefused,
    input wire logic intOut
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic cfgCmd;
    logic maskClr;
    assign cfgCmd = cmd.valid && cmd.cmd[7:3] == 5'h04 && autoRun;
    assign maskClr = cmd.valid && cmd.cmd[7:1] == 7'h0C && cmd.data[7:0] == 8'h00;
    // ==========================================================
    // Assertions
    a_pin_reset_idle: assert property ($fell(rst) |-> !intOut)
        else $error("pin high right after reset");
    a_cfg_refused_pulse: assert property (cfgCmd |=> cfgRefused)
        else $error("config access in auto mode not refused");
    a_cfg_refused_cause: assert property (cfgRefused |-> $past(cfgCmd))
        else $error("refusal without config access in auto mode");
    a_fifo_off_quiet: assert property (fifoRead && opReg[7:6] == 2'h0 |=> !fifoData.valid)
        else $error("data read from a disabled FIFO");
    a_fifo_data_cause: assert property (fifoData.valid |-> $past(fifoRead))
        else $error("FIFO data without a read");
    a_temp_keeps_press: assert property (conv.valid && conv.isTemp
        |=> lastTemp == $past(conv.result) && $stable(lastPress))
        else $error("temperature step wrong or pressure changed");
    a_press_keeps_temp: assert property (conv.valid && !conv.isTemp
        |=> lastPress == $past(conv.result) && $stable(lastTemp))
        else $error("pressure step wrong or temperature changed");
    a_rsp_after_cmd: assert property (rsp.valid |-> $past(cmd.valid))
        else $error("answer without a command");
    a_mask_zero_hides: assert property (maskClr ##1 !cmd.valid |=> !intOut)
        else $error("pin high with all mask bits zero");
    c_refused: cover property (cfgRefused);
    c_fifo_data: cover property (fifoData.valid);
    c_pin_high: cover property (intOut);
endmodule : slf_result_unit_sva

bind slf_result_unit slf_result_unit_sva #(.DEPTH(DEPTH), .PTR_W(PTR_W)) i_slf_result_unit_sva (
    .core_clk(core_clk), .rst(rst), .conv(conv), .opReg(opReg), .autoRun(autoRun), .cmd(cmd),
    .fifoRead(fifoRead), .rsp(rsp), .fifoData(fifoData), .lastTemp(lastTemp),
    .lastPress(lastPress), .cfgRefused(cfgRefused), .intOut(intOut));

// ---- dv/slf_host_model.sv ----
// Host controller model sending one-byte commands with a data word
`timescale 1ns/1ps
module slf_host_model (
    // Clock
    input wire logic core_clk,
    // Command link
    input wire slf_pkg::slf_rsp_s rsp,
    output slf_pkg::slf_cmd_s cmd
);
    initial cmd = '0;
    // Answer is taken one cycle after the command edge
    task automatic xfer(input logic [7:0] c, input logic [15:0] d, output logic [15:0] r);
        @(negedge core_clk);
        cmd = '{1'b1, c, d};
        @(negedge core_clk);
        r = rsp.valid ? rsp.data : 16'hDEAD;
        // Released data is inverted so a stale word cannot pass
        cmd = '{1'b0, 8'h00, ~d};
    endtask : xfer
endmodule : slf_host_model

// ---- dv/sensor_limit_irq_fifo_test.sv ----
// Self-checking bench for the limit, interrupt and FIFO result unit
`timescale 1ns/1ps
`include "slf_regs.svh"
module sensor_limit_irq_fifo_test;
    logic core_clk, rst, autoRun, crcFail, fifoRead, cfgRefused, intOut;
    logic [15:0] opReg, r;
    logic [23:0] lastTemp, lastPress;
    slf_pkg::slf_conv_s conv;
    slf_pkg::slf_cmd_s cmd;
    slf_pkg::slf_rsp_s rsp;
    slf_pkg::slf_pair_s fifoData;
    int err_total = 0;
    int cmp_count = 0;
    slf_result_unit i_slf_result_unit (.core_clk(core_clk), .rst(rst), .conv(conv),
        .opReg(opReg), .autoRun(autoRun), .crcFail(crcFail), .cmd(cmd), .fifoRead(fifoRead),
        .rsp(rsp), .fifoData(fifoData), .lastTemp(lastTemp), .lastPress(lastPress),
        .cfgRefused(cfgRefused), .intOut(intOut));
    slf_host_model i_slf_host_model (.core_clk(core_clk), .rsp(rsp), .cmd(cmd));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("Compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        i_slf_host_model.xfer(c, d, r);
    endtask : wr
    task automatic flags(input logic [7:0] e);
        i_slf_host_model.xfer(8'h1E, 16'h0000, r);
        check(r[7:0], e);
    endtask : flags
    task automatic cv(input logic t, input logic s, input logic [23:0] v);
        @(negedge core_clk);
        conv = '{1'b1, t, s, 1'b1, v};
        @(negedge core_clk);
        conv = '{1'b0, 1'b0, 1'b0, 1'b0, ~v};
    endtask : cv
    task automatic rd(input logic vExp, input logic [23:0] p);
        @(negedge core_clk);
        fifoRead = 1'b1;
        @(negedge core_clk);
        fifoRead = 1'b0;
        check(fifoData.valid, vExp);
        if (vExp) begin
            check(fifoData.press, p);
            check(fifoData.temp, 24'h200000);
        end
    endtask : rd
    // ==========================================================
    // Scenarios
    task automatic tLimits();
        for (int a = 0; a < 4; a++) begin
            i_slf_host_model.xfer(8'h38 | 8'(a << 1), 16'h0000, r);
            check(r, a[0] ? `SLF_LIMIT_HIGH_RST : `SLF_LIMIT_LOW_RST);
            wr(8'h30 | 8'(a << 1), 16'h1000);
            cv(a[1], 1'b0, 24'h1000FF);
            flags(8'h01);
            cv(a[1], 1'b0, a[0] ? 24'h100100 : 24'h0FFFFF);
            flags(8'h01 | (8'h08 << (a[0] + (a[1] ? 0 : 2))));
            wr(8'h1C, 16'h00FF);
            wr(8'h30 | 8'(a << 1), a[0] ? 16'hFFFF : 16'h0000);
        end
        i_slf_host_model.xfer(8'h1A, 16'h0000, r);
        check(r[7:0], `SLF_MASK_RST);
        wr(8'h36, 16'h1000);
        cv(1'b1, 1'b0, 24'h200000);
        check(intOut, 1'b0);
        check(lastTemp, 24'h200000);
        check(lastPress, 24'h100100);
        wr(8'h18, 16'h0010);
        @(negedge core_clk);
        check(intOut, 1'b1);
        wr(8'h1C, 16'h0001);
        flags(8'h10);
        wr(8'h18, 16'h0000);
        @(negedge core_clk);
        check(intOut, 1'b0);
        wr(8'h1C, 16'h0010);
        wr(8'h36, 16'h0100);
        flags(8'h00);
        wr(8'h36, 16'hFFFF);
        crcFail = 1'b1;
        flags(8'h80);
        crcFail = 1'b0;
    endtask : tLimits
    task automatic tFifo();
        opReg = 16'h0540;
        for (int i = 0; i < 33; i++) begin
            cv(1'b0, 1'b1, 24'(i));
            if (i == 3 || i == 4)
                flags(i == 3 ? 8'h01 : 8'h03);
        end
        flags(8'h07);
        for (int i = 0; i < 33; i++)
            rd(i < 32, 24'(i));
        wr(8'h1C, 16'h00FF);
        opReg = 16'h0000;
        @(negedge core_clk);
        opReg = 16'h0080;
        for (int i = 0; i < 40; i++)
            cv(1'b0, 1'b1, 24'(i));
        for (int i = 0; i < 32; i++)
            rd(i < 31, 24'(i + 9));
        cv(1'b0, 1'b1, 24'h000055);
        opReg = 16'h0000;
        rd(1'b0, 24'h000000);
        opReg = 16'h0040;
        rd(1'b0, 24'h000000);
    endtask : tFifo
    task automatic tAuto();
        autoRun = 1'b1;
        wr(8'h20, 16'h0001);
        check(cfgRefused, 1'b1);
        autoRun = 1'b0;
        wr(8'h20, 16'h0001);
        check(cfgRefused, 1'b0);
    endtask : tAuto
    initial begin
        rst = 1'b1;
        conv = '0;
        opReg = 16'h0000;
        autoRun = 1'b0;
        crcFail = 1'b0;
        fifoRead = 1'b0;
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        tLimits();
        tFifo();
        tAuto();
        summarize();
    end
    initial begin
        #50000;
        err_total++;
        summarize();
    end
endmodule : sensor_limit_irq_fifo_test
